// *** include/pmb_pkg.sv ***
package pmb_pkg;

    // *********************************************************************
    // Bank geometry and register offsets
    // *********************************************************************
    localparam int         NUM_REGS = 5;
    localparam int         REG_W    = 8;
    localparam int         ADDR_W   = 3;

    localparam logic [2:0] OFS_OSC_TIMER      = 3'h0;
    localparam logic [2:0] OFS_ANALOG_UNIT    = 3'h1;
    localparam logic [2:0] OFS_PULSE_CAPTURE  = 3'h2;
    localparam logic [2:0] OFS_SERIAL_WAVE    = 3'h3;
    localparam logic [2:0] OFS_MEASURE_LOGIC  = 3'h4;

    // *********************************************************************
    // Reset values and implemented-bit masks
    // *********************************************************************
    localparam logic [7:0] RESET_VAL          = 8'h00;
    localparam logic [7:0] MASK_OSC_TIMER     = 8'hff;
    localparam logic [7:0] MASK_ANALOG_UNIT   = 8'h67;
    localparam logic [7:0] MASK_PULSE_CAPTURE = 8'h7f;
    localparam logic [7:0] MASK_SERIAL_WAVE   = 8'h77;
    localparam logic [7:0] MASK_MEASURE_LOGIC = 8'hdf;

    // *********************************************************************
    // Field positions
    // *********************************************************************
    localparam int BIT_NUM_OSC      = 7;
    localparam int BIT_TIMER6       = 6;
    localparam int BIT_TIMER0       = 0;
    localparam int BIT_DAC          = 6;
    localparam int BIT_ADC          = 5;
    localparam int BIT_COMP2        = 2;
    localparam int BIT_COMP1        = 1;
    localparam int BIT_ZERO_CROSS   = 0;
    localparam int BIT_PULSE7       = 6;
    localparam int BIT_PULSE6       = 5;
    localparam int BIT_CAPCOMP5     = 4;
    localparam int BIT_CAPCOMP1     = 0;
    localparam int BIT_ASYNC_SER    = 6;
    localparam int BIT_SYNC_SER2    = 5;
    localparam int BIT_SYNC_SER1    = 4;
    localparam int BIT_WAVE3        = 2;
    localparam int BIT_WAVE1        = 0;
    localparam int BIT_MEAS2        = 7;
    localparam int BIT_MEAS1        = 6;
    localparam int BIT_LOGIC4       = 4;
    localparam int BIT_LOGIC1       = 1;
    localparam int BIT_MODULATOR    = 0;

    // *********************************************************************
    // Carriers
    // *********************************************************************
    typedef logic [NUM_REGS-1:0][REG_W-1:0] pmb_bank_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [REG_W-1:0]  wdata;
        logic              wr;
        logic              rd;
    } pmb_req_s;

    typedef struct packed {
        logic       num_osc_disable;
        logic [6:0] timer_disable;
        logic       dac_unit_disable;
        logic       adc_unit_disable;
        logic       comparator2_disable;
        logic       comparator1_disable;
        logic       zero_cross_disable;
        logic       pulse_unit7_disable;
        logic       pulse_unit6_disable;
        logic [4:0] capcomp_disable;
        logic       async_serial_disable;
        logic       sync_serial2_disable;
        logic       sync_serial1_disable;
        logic [2:0] waveform_gen_disable;
        logic       measure_timer2_disable;
        logic       measure_timer1_disable;
        logic [3:0] logic_cell_disable;
        logic       signal_modulator_disable;
    } pmb_disable_s;

    typedef struct packed {
        pmb_bank_t        bank;
        pmb_bank_t        run;
        logic [REG_W-1:0] rdata;
    } pmb_state_s;

endpackage : pmb_pkg

// *** core/pmb_bank.sv ***
`timescale 1ns/100ps
// Functional notes
// - Bit 7 of the first register disables the numeric oscillator; one disables.
// - Bits 6..0 of the first register disable timer6 down to timer0.
// - Second register bit 6 disables the DAC, bit 5 the ADC.
// - Second register bits 2, 1, 0 disable comparator 2, comparator 1, zero-cross.
// - Unimplemented bits read zero and ignore writes.
// - Third register bits 6, 5 disable pulse units 7, 6; bits 4..0 capture units.
// - Fourth register bit 6 async serial, bits 5, 4 sync serial, bits 2..0 waveform.
// - Fifth register bits 7, 6 measure timers, bits 4..1 logic cells, bit 0 modulator.
// - All implemented bits are read/write and reset to zero on any reset.
// - A disabled peripheral is clock-gated, held in reset, registers dead.
// - Clearing a bit releases the peripheral from its reset state at once.
// - Disabling a peripheral also disables its input-selection registers.
module pmb_bank #(
    parameter int ADDR_W = pmb_pkg::ADDR_W
) (
    // Clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 nrst_i,
    // Register port
    input  wire pmb_pkg::pmb_req_s    req_i,
    output      logic [7:0]           rdata_o,
    // Peripheral controls
    output      pmb_pkg::pmb_disable_s disable_o,
    output      pmb_pkg::pmb_bank_t   run_o
);

    // *********************************************************************
    // Elaboration checks
    // *********************************************************************
    if (ADDR_W != pmb_pkg::ADDR_W) begin : g_bad_addr
        $error("pmb_bank: address width must match the register port");
    end

    // *********************************************************************
    // Helpers
    // *********************************************************************
    function automatic logic [7:0] impl_mask(input logic [2:0] idx);
        logic [7:0] m;
        m = 8'h00;
        case (idx)
            pmb_pkg::OFS_OSC_TIMER:     m = pmb_pkg::MASK_OSC_TIMER;
            pmb_pkg::OFS_ANALOG_UNIT:   m = pmb_pkg::MASK_ANALOG_UNIT;
            pmb_pkg::OFS_PULSE_CAPTURE: m = pmb_pkg::MASK_PULSE_CAPTURE;
            pmb_pkg::OFS_SERIAL_WAVE:   m = pmb_pkg::MASK_SERIAL_WAVE;
            pmb_pkg::OFS_MEASURE_LOGIC: m = pmb_pkg::MASK_MEASURE_LOGIC;
            default:                    m = 8'h00;
        endcase
        return m;
    endfunction : impl_mask

    function automatic logic is_mapped(input logic [2:0] idx);
        return idx < 3'(pmb_pkg::NUM_REGS);
    endfunction : is_mapped

    // Unmapped addresses read as zero rather than aliasing a register.
    function automatic logic [7:0] read_mux(input pmb_pkg::pmb_bank_t b,
                                            input logic [2:0] idx);
        logic [7:0] v;
        v = 8'h00;
        if (is_mapped(idx)) begin
            v = b[idx] & impl_mask(idx);
        end
        return v;
    endfunction : read_mux

    // *********************************************************************
    // State
    // *********************************************************************
    pmb_pkg::pmb_state_s st;
    pmb_pkg::pmb_state_s next_st;

    always_comb begin
        next_st       = st;
        next_st.rdata = 8'h00;
        if (req_i.wr && is_mapped(req_i.addr)) begin
            // Reserved positions are masked off so they never store a one.
            next_st.bank[req_i.addr] = req_i.wdata & impl_mask(req_i.addr);
        end
        if (req_i.rd) begin
            next_st.rdata = read_mux(st.bank, req_i.addr);
        end
        for (int i = 0; i < pmb_pkg::NUM_REGS; i++) begin
            // Run enable drops in the same edge the disable rises, so clock gate,
            // reset hold and selection gating never lag the register.
            next_st.run[i] = ~next_st.bank[i] & impl_mask(3'(i));
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            st.bank  <= '0;
            st.rdata <= pmb_pkg::RESET_VAL;
            st.run   <= {pmb_pkg::MASK_MEASURE_LOGIC, pmb_pkg::MASK_SERIAL_WAVE,
                         pmb_pkg::MASK_PULSE_CAPTURE, pmb_pkg::MASK_ANALOG_UNIT,
                         pmb_pkg::MASK_OSC_TIMER};
        end else begin
            st <= next_st;
        end
    end

    // *********************************************************************
    // Outputs
    // *********************************************************************
    localparam int R1 = 0;
    localparam int R2 = 1;
    localparam int R3 = 2;
    localparam int R4 = 3;
    localparam int R5 = 4;

    assign rdata_o = st.rdata;
    assign run_o   = st.run;

    always_comb begin
        disable_o.num_osc_disable          = st.bank[R1][pmb_pkg::BIT_NUM_OSC];
        disable_o.timer_disable            =
            st.bank[R1][pmb_pkg::BIT_TIMER6:pmb_pkg::BIT_TIMER0];
        disable_o.dac_unit_disable         = st.bank[R2][pmb_pkg::BIT_DAC];
        disable_o.adc_unit_disable         = st.bank[R2][pmb_pkg::BIT_ADC];
        disable_o.comparator2_disable      = st.bank[R2][pmb_pkg::BIT_COMP2];
        disable_o.comparator1_disable      = st.bank[R2][pmb_pkg::BIT_COMP1];
        disable_o.zero_cross_disable       = st.bank[R2][pmb_pkg::BIT_ZERO_CROSS];
        disable_o.pulse_unit7_disable      = st.bank[R3][pmb_pkg::BIT_PULSE7];
        disable_o.pulse_unit6_disable      = st.bank[R3][pmb_pkg::BIT_PULSE6];
        disable_o.capcomp_disable          =
            st.bank[R3][pmb_pkg::BIT_CAPCOMP5:pmb_pkg::BIT_CAPCOMP1];
        disable_o.async_serial_disable     = st.bank[R4][pmb_pkg::BIT_ASYNC_SER];
        disable_o.sync_serial2_disable     = st.bank[R4][pmb_pkg::BIT_SYNC_SER2];
        disable_o.sync_serial1_disable     = st.bank[R4][pmb_pkg::BIT_SYNC_SER1];
        disable_o.waveform_gen_disable     =
            st.bank[R4][pmb_pkg::BIT_WAVE3:pmb_pkg::BIT_WAVE1];
        disable_o.measure_timer2_disable   = st.bank[R5][pmb_pkg::BIT_MEAS2];
        disable_o.measure_timer1_disable   = st.bank[R5][pmb_pkg::BIT_MEAS1];
        disable_o.logic_cell_disable       =
            st.bank[R5][pmb_pkg::BIT_LOGIC4:pmb_pkg::BIT_LOGIC1];
        disable_o.signal_modulator_disable = st.bank[R5][pmb_pkg::BIT_MODULATOR];
    end

    // *********************************************************************
    // Assertions
    // *********************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    a_nco_write_map: assert property (
        req_i.wr && req_i.addr == pmb_pkg::OFS_OSC_TIMER |=>
        disable_o.num_osc_disable == $past(req_i.wdata[7]))
        else $error("oscillator disable does not follow write");

    a_timer_write_map: assert property (
        req_i.wr && req_i.addr == pmb_pkg::OFS_OSC_TIMER |=>
        disable_o.timer_disable == $past(req_i.wdata[6:0]))
        else $error("timer disables do not follow write");

    a_converter_write_map: assert property (
        req_i.wr && req_i.addr == pmb_pkg::OFS_ANALOG_UNIT |=>
        {disable_o.dac_unit_disable, disable_o.adc_unit_disable}
        == $past(req_i.wdata[6:5]))
        else $error("converter disables do not follow write");

    a_comparator_write_map: assert property (
        req_i.wr && req_i.addr == pmb_pkg::OFS_ANALOG_UNIT |=>
        {disable_o.comparator2_disable, disable_o.comparator1_disable,
         disable_o.zero_cross_disable} == $past(req_i.wdata[2:0]))
        else $error("comparator disables do not follow write");

    a_reserved_read_zero: assert property (
        req_i.rd |=> (rdata_o & ~impl_mask($past(req_i.addr))) == 8'h00)
        else $error("reserved bit read back as one");

    a_pulse_write_map: assert property (
        req_i.wr && req_i.addr == pmb_pkg::OFS_PULSE_CAPTURE |=>
        {disable_o.pulse_unit7_disable, disable_o.pulse_unit6_disable,
         disable_o.capcomp_disable} == $past(req_i.wdata[6:0]))
        else $error("pulse and capture disables do not follow write");

    a_serial_write_map: assert property (
        req_i.wr && req_i.addr == pmb_pkg::OFS_SERIAL_WAVE |=>
        {disable_o.async_serial_disable, disable_o.sync_serial2_disable,
         disable_o.sync_serial1_disable, disable_o.waveform_gen_disable}
        == {$past(req_i.wdata[6:4]), $past(req_i.wdata[2:0])})
        else $error("serial and waveform disables do not follow write");

    a_measure_write_map: assert property (
        req_i.wr && req_i.addr == pmb_pkg::OFS_MEASURE_LOGIC |=>
        {disable_o.measure_timer2_disable, disable_o.measure_timer1_disable,
         disable_o.logic_cell_disable, disable_o.signal_modulator_disable}
        == {$past(req_i.wdata[7:6]), $past(req_i.wdata[4:0])})
        else $error("measure and logic disables do not follow write");

    a_reset_clears_bank: assert property (disable iff (1'b0)
        !nrst_i |=> disable_o == '0 && rdata_o == 8'h00)
        else $error("disable bits not cleared by reset");

    a_gate_on_disable: assert property (
        $rose(disable_o.adc_unit_disable) |-> $fell(run_o[R2][pmb_pkg::BIT_ADC]))
        else $error("run enable did not drop with the disable");

    a_restart_on_clear: assert property (
        $fell(disable_o.num_osc_disable) |-> $rose(run_o[R1][pmb_pkg::BIT_NUM_OSC]))
        else $error("run enable did not return with the clear");

    a_select_gate_held: assert property (
        disable_o.measure_timer1_disable |-> !run_o[R5][pmb_pkg::BIT_MEAS1])
        else $error("selection gating lost while disabled");

    a_level_hold: assert property (
        (!req_i.wr && nrst_i) [*2] |=> $stable(disable_o) && $stable(run_o))
        else $error("disable level changed without a write");

    a_read_one_cycle: assert property (
        req_i.rd |=> rdata_o == read_mux($past(st.bank), $past(req_i.addr)))
        else $error("read data wrong in the cycle after the strobe");

    // *********************************************************************
    // Run enables against the stored disables
    // *********************************************************************
    a_run_osc_timer: assert property (
        run_o[R1] == (~st.bank[R1] & pmb_pkg::MASK_OSC_TIMER))
        else $error("oscillator and timer run enables do not track the disables");

    a_run_analog: assert property (
        run_o[R2] == (~st.bank[R2] & pmb_pkg::MASK_ANALOG_UNIT))
        else $error("analog run enables do not track the disables");

    a_run_pulse: assert property (
        run_o[R3] == (~st.bank[R3] & pmb_pkg::MASK_PULSE_CAPTURE))
        else $error("pulse and capture run enables do not track the disables");

    a_run_serial: assert property (
        run_o[R4] == (~st.bank[R4] & pmb_pkg::MASK_SERIAL_WAVE))
        else $error("serial and waveform run enables do not track the disables");

    a_run_measure: assert property (
        run_o[R5] == (~st.bank[R5] & pmb_pkg::MASK_MEASURE_LOGIC))
        else $error("measure and logic run enables do not track the disables");

    a_reset_runs_all: assert property (disable iff (1'b0)
        !nrst_i |=> run_o == {pmb_pkg::MASK_MEASURE_LOGIC, pmb_pkg::MASK_SERIAL_WAVE,
                              pmb_pkg::MASK_PULSE_CAPTURE, pmb_pkg::MASK_ANALOG_UNIT,
                              pmb_pkg::MASK_OSC_TIMER})
        else $error("run enables not all set by reset");

    // *********************************************************************
    // Reserved positions never hold a one
    // *********************************************************************
    a_reserved_analog: assert property (
        (st.bank[R2] & ~pmb_pkg::MASK_ANALOG_UNIT) == 8'h00)
        else $error("reserved bit stored in the analog register");

    a_reserved_pulse: assert property (
        (st.bank[R3] & ~pmb_pkg::MASK_PULSE_CAPTURE) == 8'h00)
        else $error("reserved bit stored in the pulse register");

    a_reserved_serial: assert property (
        (st.bank[R4] & ~pmb_pkg::MASK_SERIAL_WAVE) == 8'h00)
        else $error("reserved bit stored in the serial register");

    a_reserved_measure: assert property (
        (st.bank[R5] & ~pmb_pkg::MASK_MEASURE_LOGIC) == 8'h00)
        else $error("reserved bit stored in the measure register");

    // *********************************************************************
    // Access side effects
    // *********************************************************************
    a_unmapped_write_dead: assert property (
        req_i.wr && !is_mapped(req_i.addr) |=> $stable(st.bank))
        else $error("write to an unmapped index changed the bank");

    a_read_no_effect: assert property (
        req_i.rd && !req_i.wr |=> $stable(st.bank))
        else $error("read changed the bank");

    a_idle_read_zero: assert property (
        !req_i.rd |=> rdata_o == 8'h00)
        else $error("read data not zero outside the read cycle");

    // A write touches its own register only; the others keep their level.
    a_keep_osc_timer: assert property (
        req_i.wr && req_i.addr != pmb_pkg::OFS_OSC_TIMER |=> $stable(st.bank[R1]))
        else $error("oscillator register changed by another write");

    a_keep_analog: assert property (
        req_i.wr && req_i.addr != pmb_pkg::OFS_ANALOG_UNIT |=> $stable(st.bank[R2]))
        else $error("analog register changed by another write");

    a_keep_pulse: assert property (
        req_i.wr && req_i.addr != pmb_pkg::OFS_PULSE_CAPTURE |=> $stable(st.bank[R3]))
        else $error("pulse register changed by another write");

    a_keep_serial: assert property (
        req_i.wr && req_i.addr != pmb_pkg::OFS_SERIAL_WAVE |=> $stable(st.bank[R4]))
        else $error("serial register changed by another write");

    a_keep_measure: assert property (
        req_i.wr && req_i.addr != pmb_pkg::OFS_MEASURE_LOGIC |=> $stable(st.bank[R5]))
        else $error("measure register changed by another write");

    // *********************************************************************
    // Read data against the disable levels
    // *********************************************************************
    a_read_osc_timer: assert property (
        req_i.rd && req_i.addr == pmb_pkg::OFS_OSC_TIMER |=>
        rdata_o == $past({disable_o.num_osc_disable, disable_o.timer_disable}))
        else $error("oscillator register read disagrees with its disables");

    a_read_analog: assert property (
        req_i.rd && req_i.addr == pmb_pkg::OFS_ANALOG_UNIT |=>
        rdata_o == $past({1'b0, disable_o.dac_unit_disable, disable_o.adc_unit_disable,
                          2'b00, disable_o.comparator2_disable,
                          disable_o.comparator1_disable, disable_o.zero_cross_disable}))
        else $error("analog register read disagrees with its disables");

    a_read_pulse: assert property (
        req_i.rd && req_i.addr == pmb_pkg::OFS_PULSE_CAPTURE |=>
        rdata_o == $past({1'b0, disable_o.pulse_unit7_disable, disable_o.pulse_unit6_disable,
                          disable_o.capcomp_disable}))
        else $error("pulse register read disagrees with its disables");

    a_read_serial: assert property (
        req_i.rd && req_i.addr == pmb_pkg::OFS_SERIAL_WAVE |=>
        rdata_o == $past({1'b0, disable_o.async_serial_disable,
                          disable_o.sync_serial2_disable, disable_o.sync_serial1_disable,
                          1'b0, disable_o.waveform_gen_disable}))
        else $error("serial register read disagrees with its disables");

    a_read_measure: assert property (
        req_i.rd && req_i.addr == pmb_pkg::OFS_MEASURE_LOGIC |=>
        rdata_o == $past({disable_o.measure_timer2_disable, disable_o.measure_timer1_disable,
                          1'b0, disable_o.logic_cell_disable,
                          disable_o.signal_modulator_disable}))
        else $error("measure register read disagrees with its disables");

    c_write_readback: cover property (
        req_i.wr && req_i.wdata != 8'h00 ##1 req_i.rd && rdata_o == 8'h00 ##1
        rdata_o != 8'h00);

    c_disable_reenable: cover property (
        $rose(disable_o.async_serial_disable) ##[1:20] $fell(disable_o.async_serial_disable));

    c_unmapped_read: cover property (req_i.rd && !is_mapped(req_i.addr));

    c_all_disabled: cover property (disable_o == '1);

    c_midrun_reset: cover property (disable iff (1'b0) !nrst_i && $past(disable_o != '0));

endmodule : pmb_bank

// *** tb/pmb_bank_tb.sv ***
`timescale 1ns/100ps
module pmb_bank_tb;

    // *********************************************************************
    // Signals and expectations
    // *********************************************************************
    logic                  clk_i;
    logic                  nrst_i;
    pmb_pkg::pmb_req_s     req_i;
    logic [7:0]            rdata_o;
    pmb_pkg::pmb_disable_s disable_o;
    pmb_pkg::pmb_bank_t    run_o;
    logic [7:0]            sh [5];
    logic [7:0]            msk [5];
    logic [7:0]            d;
    int                    n_fail;
    int                    check_count;

    pmb_bank pmb_bank_inst (
        .clk_i     (clk_i),
        .nrst_i    (nrst_i),
        .req_i     (req_i),
        .rdata_o   (rdata_o),
        .disable_o (disable_o),
        .run_o     (run_o)
    );

    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    // Expected controls are rebuilt from the shadow bank, one control bit per implemented bit.
    function automatic pmb_pkg::pmb_disable_s exp_dis();
        return {sh[0], sh[1][6], sh[1][5], sh[1][2:0], sh[2][6:0], sh[3][6:4], sh[3][2:0],
                sh[4][7:6], sh[4][4:0]};
    endfunction : exp_dis

    function automatic pmb_pkg::pmb_bank_t exp_run();
        pmb_pkg::pmb_bank_t r;
        for (int i = 0; i < 5; i++) r[i] = msk[i] & ~sh[i];
        return r;
    endfunction : exp_run

    // *********************************************************************
    // Bus and compare tasks
    // *********************************************************************
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk_i);
        req_i.addr  <= a;
        req_i.wdata <= v;
        req_i.wr    <= 1'b1;
        @(posedge clk_i);
        req_i.wr <= 1'b0;
        #1;
        if (a < 3'h5) sh[a] = v & msk[a];
    endtask : wr

    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge clk_i);
        req_i.addr <= a;
        req_i.rd   <= 1'b1;
        @(posedge clk_i);
        req_i.rd <= 1'b0;
        #1;
        v = rdata_o;
        @(posedge clk_i);
        #1;
        chk(40'(rdata_o), 40'h0);
    endtask : rd

    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : wrap_up

    // *********************************************************************
    // Scenarios
    // *********************************************************************
    task automatic t_reset();
        chk(40'(disable_o), 40'h0);
        chk(run_o, exp_run());
        for (int i = 0; i < 8; i++) begin
            rd(3'(i), d);
            chk(40'(d), 40'h0);
        end
    endtask : t_reset

    // One bit at a time proves each field lands on its own control and no other.
    task automatic t_walk();
        for (int r = 0; r < 5; r++) begin
            for (int b = 0; b < 8; b++) begin
                wr(3'(r), 8'h01 << b);
                chk(40'(disable_o), 40'(exp_dis()));
                chk(run_o, exp_run());
                rd(3'(r), d);
                chk(40'(d), 40'(sh[r]));
                wr(3'(r), 8'h00);
                chk(run_o, exp_run());
            end
        end
    endtask : t_walk

    task automatic t_full();
        for (int r = 0; r < 5; r++) begin
            wr(3'(r), 8'hff);
            rd(3'(r), d);
            chk(40'(d), 40'(msk[r]));
        end
        chk(40'(disable_o), 40'h1ffffffff);
    endtask : t_full

    task automatic t_unmapped();
        for (int a = 5; a < 8; a++) begin
            wr(3'(a), 8'h00);
            chk(40'(disable_o), 40'(exp_dis()));
            rd(3'(a), d);
            chk(40'(d), 40'h0);
        end
    endtask : t_unmapped

    // A read issued in the cycle right after the write must already see the new value.
    task automatic t_b2b();
        @(posedge clk_i);
        req_i.addr  <= 3'h1;
        req_i.wdata <= 8'h20;
        req_i.wr    <= 1'b1;
        @(posedge clk_i);
        req_i.wr <= 1'b0;
        req_i.rd <= 1'b1;
        @(posedge clk_i);
        req_i.rd <= 1'b0;
        sh[1] = 8'h20;
        #1;
        chk(40'(rdata_o), 40'h20);
        chk(40'(disable_o.adc_unit_disable), 40'h1);
        @(posedge clk_i);
        #1;
        chk(40'(rdata_o), 40'h0);
    endtask : t_b2b

    task automatic t_midreset();
        @(posedge clk_i);
        nrst_i <= 1'b0;
        @(posedge clk_i);
        nrst_i <= 1'b1;
        for (int i = 0; i < 5; i++) sh[i] = 8'h00;
        #1;
        chk(40'(disable_o), 40'h0);
        chk(run_o, exp_run());
    endtask : t_midreset

    // *********************************************************************
    // Main sequence and watchdog
    // *********************************************************************
    initial begin
        nrst_i      = 1'b0;
        req_i       = '0;
        n_fail      = 0;
        check_count = 0;
        msk = '{pmb_pkg::MASK_OSC_TIMER, pmb_pkg::MASK_ANALOG_UNIT,
                pmb_pkg::MASK_PULSE_CAPTURE, pmb_pkg::MASK_SERIAL_WAVE,
                pmb_pkg::MASK_MEASURE_LOGIC};
        for (int i = 0; i < 5; i++) sh[i] = 8'h00;
        repeat (5) @(posedge clk_i);
        nrst_i <= 1'b1;
        #1;
        t_reset();
        t_walk();
        t_unmapped();
        t_full();
        t_unmapped();
        t_b2b();
        t_midreset();
        wrap_up();
    end

    // The whole sequence needs about 370 cycles; this leaves a wide margin.
    initial begin
        #(4 * 5000);
        n_fail++;
        wrap_up();
    end

endmodule : pmb_bank_tb
